// [dv/gicr_regs_bench.sv]
// Directed test bench for the register bank.
`timescale 1ns/1ps
`default_nettype none
module gicr_regs_bench;
    import gicr_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [ADDR_W-1:0] addr = 6'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [7:1] oth_en = 7'h00;
    logic [23:0] setup = 24'h000000;
    logic done = 1'b0;
    logic [2:0] act_ch;
    logic [2:0] act_setup;
    logic ch0_en;
    logic [2:0] ch0_setup;
    logic p0_in = 1'b0;
    logic p1_in = 1'b0;
    logic p0_out, p0_oe_n, p1_out, p1_oe_n;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] r;
    int fails = 0;
    int checks = 0;

    gicr_regs dut (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .other_ch_enable_in(oth_en), .ch_setup_in(setup), .conv_done_in(done),
        .active_ch_out(act_ch), .active_setup_out(act_setup), .channel_zero_enable_out(ch0_en),
        .channel_zero_setup_index_out(ch0_setup), .general_pin_zero_in(p0_in),
        .general_pin_zero_out(p0_out), .general_pin_zero_oe_n_out(p0_oe_n),
        .general_pin_one_in(p1_in), .general_pin_one_out(p1_out),
        .general_pin_one_oe_n_out(p1_oe_n));

    initial
    begin
        forever #25 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask

    // The answer is due exactly one cycle after the strobe.
    task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        check("rvalid", {15'h0000, rvalid}, 16'h0001);
        d = rdata;
    endtask

    task automatic pulse();
        @(posedge clk_in);
        done <= 1'b1;
        @(posedge clk_in);
        done <= 1'b0;
        #1;
    endtask

    initial
    begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        read(CH0_ADDR, r);
        check("ch0 reset", r, 16'h8001);
        read(PIN_CTRL_ADDR, r);
        check("pin ctrl reset", r, 16'h0000);
        write(ID_ADDR, 16'hFFFF);
        read(ID_ADDR, r);
        check("id code", r, ID_DEFAULT);
        read(6'h3F, r);
        check("unmapped", r, 16'h0000);
        $display("test reset and id done");
        // Pins follow the control register one edge after the write lands.
        write(PIN_CTRL_ADDR, 16'h000D);
        @(posedge clk_in);
        #1;
        check("pin out", {14'h0000, p1_out, p0_out}, 16'h0001);
        check("pin oe_n", {14'h0000, p1_oe_n, p0_oe_n}, 16'h0000);
        write(PIN_CTRL_ADDR, 16'h0002);
        @(posedge clk_in);
        #1;
        check("pin off oe_n", {14'h0000, p1_oe_n, p0_oe_n}, 16'h0003);
        read(PIN_CTRL_ADDR, r);
        check("pin data kept", r, 16'h0002);
        write(PIN_CTRL_ADDR, 16'h0030);
        @(posedge clk_in);
        {p1_in, p0_in} <= 2'b01;
        repeat (3) @(posedge clk_in);
        read(PIN_CTRL_ADDR, r);
        check("pin input 0", r, 16'h0031);
        check("input oe_n", {14'h0000, p1_oe_n, p0_oe_n}, 16'h0003);
        @(posedge clk_in);
        {p1_in, p0_in} <= 2'b10;
        repeat (3) @(posedge clk_in);
        read(PIN_CTRL_ADDR, r);
        check("pin input 1", r, 16'h0032);
        write(PIN_CTRL_ADDR, 16'hFFC0);
        read(PIN_CTRL_ADDR, r);
        check("pin reserved", r, 16'h0000);
        $display("test pins done");
        for (int s = 0; s < 8; s++)
        begin
            v = {1'(s != 5), 3'(s), 12'hFFF};
            write(CH0_ADDR, v);
            check("setup index", {13'h0000, ch0_setup}, 16'(s));
            check("ch0 enable", {15'h0000, ch0_en}, {15'h0000, v[15]});
            read(CH0_ADDR, r);
            check("ch0 readback", r, v & CH0_WRITE_MASK);
        end
        $display("test channel fields done");
        @(posedge clk_in);
        setup <= 24'h000140;
        oth_en[2] <= 1'b1;
        pulse();
        check("step ch", {13'h0000, act_ch}, 16'h0002);
        check("step setup", {13'h0000, act_setup}, 16'h0005);
        pulse();
        check("wrap ch", {13'h0000, act_ch}, 16'h0000);
        check("wrap setup", {13'h0000, act_setup}, 16'h0007);
        // Software shares setup seven by writing that index into every active channel.
        write(CH0_ADDR, 16'hF000);
        @(posedge clk_in);
        setup <= 24'hFFFFFF;
        pulse();
        check("shared ch", {13'h0000, act_ch}, 16'h0002);
        check("shared setup 2", {13'h0000, act_setup}, 16'h0007);
        pulse();
        check("shared back", {13'h0000, act_ch}, 16'h0000);
        check("shared setup 0", {13'h0000, act_setup}, 16'h0007);
        @(posedge clk_in);
        oth_en <= 7'h00;
        pulse();
        check("single ch", {13'h0000, act_ch}, 16'h0000);
        $display("test sequencing done");
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        read(CH0_ADDR, r);
        check("ch0 second reset", r, 16'h8001);
        read(PIN_CTRL_ADDR, r);
        check("pin ctrl second reset", r, 16'h0000);
        check("oe_n second reset", {14'h0000, p1_oe_n, p0_oe_n}, 16'h0003);
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire

// [dv/gicr_regs_monitor.sv]
// Concurrent checks on the register bank ports.
`timescale 1ns/1ps
`default_nettype none
module gicr_regs_monitor
    import gicr_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter logic [DATA_W-1:0] ID_CODE = ID_DEFAULT
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic [NUM_CH-1:1] other_ch_enable_in,
    input wire logic conv_done_in,
    input wire logic [$clog2(NUM_CH)-1:0] active_ch_out,
    input wire logic [SETUP_W-1:0] active_setup_out,
    input wire logic channel_zero_enable_out,
    input wire logic [SETUP_W-1:0] channel_zero_setup_index_out,
    input wire logic general_pin_zero_out,
    input wire logic general_pin_zero_oe_n_out,
    input wire logic general_pin_one_out,
    input wire logic general_pin_one_oe_n_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    chk_read_answer_pulse: assert property (
        !srst_in |=> reg_rvalid_out == $past(reg_rd_in))
        else $error("read answer not one cycle later");
    chk_id_read_value: assert property (
        reg_rd_in && reg_addr_in == ID_ADDR |=> reg_rdata_out == ID_CODE)
        else $error("id register read wrong");
    chk_after_reset_state: assert property (
        $fell(srst_in) |-> channel_zero_enable_out && channel_zero_setup_index_out == 3'h0 &&
        general_pin_zero_oe_n_out && general_pin_one_oe_n_out)
        else $error("reset state wrong");
    // The pin cell registers the control bits once more, so pins follow two edges later.
    chk_pin_zero_drive: assert property (
        reg_wr_in && reg_addr_in == PIN_CTRL_ADDR |=> ##1
        general_pin_zero_oe_n_out == !$past(reg_wdata_in[PIN0_OUT_EN_BIT], 2) &&
        (general_pin_zero_oe_n_out ||
        general_pin_zero_out == $past(reg_wdata_in[PIN0_LEVEL_BIT], 2)))
        else $error("pin zero drive wrong");
    chk_pin_one_drive: assert property (
        reg_wr_in && reg_addr_in == PIN_CTRL_ADDR |=> ##1
        general_pin_one_oe_n_out == !$past(reg_wdata_in[PIN1_OUT_EN_BIT], 2) &&
        (general_pin_one_oe_n_out ||
        general_pin_one_out == $past(reg_wdata_in[PIN1_LEVEL_BIT], 2)))
        else $error("pin one drive wrong");
    chk_ch0_field_write: assert property (
        reg_wr_in && reg_addr_in == CH0_ADDR |=>
        channel_zero_enable_out == $past(reg_wdata_in[CH_EN_BIT]) &&
        channel_zero_setup_index_out == $past(reg_wdata_in[SETUP_HI:SETUP_LO]))
        else $error("channel zero fields wrong");
    chk_step_to_next: assert property (
        conv_done_in && active_ch_out == 0 && channel_zero_enable_out &&
        other_ch_enable_in == 7'h02 |=> active_ch_out == 2)
        else $error("sequencer did not step");
    chk_step_stay_single: assert property (
        conv_done_in && active_ch_out == 0 && channel_zero_enable_out &&
        other_ch_enable_in == 7'h00 |=> $stable(active_ch_out))
        else $error("single channel moved");
    chk_active_setup_sel: assert property (
        active_ch_out == 0 |-> active_setup_out == channel_zero_setup_index_out)
        else $error("active setup wrong");
endmodule
bind gicr_regs gicr_regs_monitor #(.NUM_CH(NUM_CH), .ID_CODE(ID_CODE)) mon (.clk_in, .srst_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
    .other_ch_enable_in, .conv_done_in, .active_ch_out, .active_setup_out,
    .channel_zero_enable_out, .channel_zero_setup_index_out, .general_pin_zero_out,
    .general_pin_zero_oe_n_out, .general_pin_one_out, .general_pin_one_oe_n_out);
`default_nettype wire

// [verilog/gicr_pin_cell.sv]
// Drivers and input synchronisers for the two general-purpose pins.
`timescale 1ns/1ps
`default_nettype none
module gicr_pin_cell
    import gicr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Register side
    gicr_pin_if.pin_side ctl,
    // Pin zero
    input wire logic general_pin_zero_in,
    output logic general_pin_zero_out,
    output logic general_pin_zero_oe_n_out,
    // Pin one
    input wire logic general_pin_one_in,
    output logic general_pin_one_out,
    output logic general_pin_one_oe_n_out
);
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic [1:0] drive_ff;
    logic [1:0] oe_n_ff;

    // Pins come from outside, so they pass two flip-flops before use.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            meta_ff <= 2'h0;
            sync_ff <= 2'h0;
        end
        else
        begin
            meta_ff <= {general_pin_one_in, general_pin_zero_in};
            sync_ff <= meta_ff;
        end
    end

    // A pin with its output enable clear is left undriven.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            drive_ff <= 2'h0;
            oe_n_ff <= 2'h3;
        end
        else
        begin
            drive_ff <= {ctl.pin1_level, ctl.pin0_level};
            oe_n_ff <= {~ctl.pin1_output_enable, ~ctl.pin0_output_enable};
        end
    end

    assign ctl.pin0_sampled = sync_ff[0];
    assign ctl.pin1_sampled = sync_ff[1];
    assign general_pin_zero_out = drive_ff[0];
    assign general_pin_one_out = drive_ff[1];
    assign general_pin_zero_oe_n_out = oe_n_ff[0];
    assign general_pin_one_oe_n_out = oe_n_ff[1];
endmodule
`default_nettype wire

// [verilog/gicr_pin_if.sv]
// Carrier between the register bank and its general-purpose pin cell.
`timescale 1ns/1ps
`default_nettype none
interface gicr_pin_if;
    logic pin0_input_enable;
    logic pin1_input_enable;
    logic pin0_output_enable;
    logic pin1_output_enable;
    logic pin0_level;
    logic pin1_level;
    logic pin0_sampled;
    logic pin1_sampled;

    modport reg_side (
        output pin0_input_enable, pin1_input_enable, pin0_output_enable,
        output pin1_output_enable, pin0_level, pin1_level,
        input pin0_sampled, pin1_sampled
    );
    modport pin_side (
        input pin0_input_enable, pin1_input_enable, pin0_output_enable,
        input pin1_output_enable, pin0_level, pin1_level,
        output pin0_sampled, pin1_sampled
    );
endinterface
`default_nettype wire

// [verilog/gicr_pkg.sv]
// Shared constants for the pin, identification and channel register bank.
package gicr_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int SETUP_W = 3;

    localparam logic [ADDR_W-1:0] PIN_CTRL_ADDR = 6'h06;
    localparam logic [ADDR_W-1:0] ID_ADDR = 6'h07;
    localparam logic [ADDR_W-1:0] CH0_ADDR = 6'h10;

    localparam int PIN1_IN_EN_BIT = 5;
    localparam int PIN0_IN_EN_BIT = 4;
    localparam int PIN1_OUT_EN_BIT = 3;
    localparam int PIN0_OUT_EN_BIT = 2;
    localparam int PIN1_LEVEL_BIT = 1;
    localparam int PIN0_LEVEL_BIT = 0;
    localparam logic [DATA_W-1:0] PIN_CTRL_RESET = 16'h0000;

    localparam int CH_EN_BIT = 15;
    localparam int SETUP_HI = 14;
    localparam int SETUP_LO = 12;
    localparam logic [DATA_W-1:0] CH0_RESET = 16'h8001;
    localparam logic [DATA_W-1:0] CH0_WRITE_MASK = 16'hF3FF;

    // Arbitrary neutral identification value.
    localparam logic [DATA_W-1:0] ID_DEFAULT = 16'h5A3C;
    localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
endpackage

// [verilog/gicr_regs.sv]
// Pin control, identification and channel zero registers with channel stepping.
// Operation
// - Pin control bit 4 makes pin zero an input when 1 and resets to 0.
// - Pin control bit 3 turns on the pin one driver when 1 and resets to 0.
// - Pin control bit 2 turns on the pin zero driver when 1 and resets to 0.
// - Pin control bit 1 is the driven level of pin one, or its sampled level as input.
// - Pin control bit 0 is the driven level of pin zero, or its sampled level as input.
// - The register at 0x07 is a read-only 16-bit code naming the converter type.
// - Channel zero configuration is a 16-bit register at 0x10 that resets to 0x8001.
// - Channel zero configuration bit 15 enables channel zero and is set after reset.
// - With two or more channels enabled the device steps through them on its own.
// - Bits 14 to 12 pick one of eight setups by index and reset to zero.
// - The channel being converted uses the setup its index selects.
// - Pin control bit 5 makes pin one an input when 1 and resets to 0.
`timescale 1ns/1ps
`default_nettype none
module gicr_regs
    import gicr_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter logic [DATA_W-1:0] ID_CODE = ID_DEFAULT
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Other channel registers and conversion timing
    input wire logic [NUM_CH-1:1] other_ch_enable_in,
    input wire logic [SETUP_W*NUM_CH-1:0] ch_setup_in,
    input wire logic conv_done_in,
    // Channel sequencing
    output logic [$clog2(NUM_CH)-1:0] active_ch_out,
    output logic [SETUP_W-1:0] active_setup_out,
    output logic channel_zero_enable_out,
    output logic [SETUP_W-1:0] channel_zero_setup_index_out,
    // General-purpose pins
    input wire logic general_pin_zero_in,
    output logic general_pin_zero_out,
    output logic general_pin_zero_oe_n_out,
    input wire logic general_pin_one_in,
    output logic general_pin_one_out,
    output logic general_pin_one_oe_n_out
);
    localparam int CH_W = $clog2(NUM_CH);

    logic [DATA_W-1:0] pin_ctrl_ff;
    logic [DATA_W-1:0] ch0_cfg_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic rvalid_ff;
    logic [CH_W-1:0] active_ch_ff;
    logic [NUM_CH-1:0] ch_enables;
    logic [DATA_W-1:0] pin_readback;
    logic [DATA_W-1:0] nxt_rdata;

    gicr_pin_if pins ();

    // Returns the next enabled channel after cur, wrapping; cur when none is.
    function automatic logic [CH_W-1:0] next_enabled(
        input logic [NUM_CH-1:0] en,
        input logic [CH_W-1:0] cur
    );
        logic [CH_W-1:0] pick;
        logic found;
        int idx;
        pick = cur;
        found = 1'b0;
        for (int k = 1; k <= NUM_CH; k++)
        begin
            idx = (int'(cur) + k) % NUM_CH;
            if (!found && en[idx])
            begin
                pick = CH_W'(idx);
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // True when the write strobe targets the given register.
    function automatic logic write_hit(
        input logic wr,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return wr && (addr == target);
    endfunction

    // Pin control: only bits 5..0 exist; the rest read back as zero.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            pin_ctrl_ff <= PIN_CTRL_RESET;
        end
        else if (write_hit(reg_wr_in, reg_addr_in, PIN_CTRL_ADDR))
        begin
            pin_ctrl_ff[PIN1_IN_EN_BIT] <= reg_wdata_in[PIN1_IN_EN_BIT];
            pin_ctrl_ff[PIN0_IN_EN_BIT] <= reg_wdata_in[PIN0_IN_EN_BIT];
            pin_ctrl_ff[PIN1_OUT_EN_BIT] <= reg_wdata_in[PIN1_OUT_EN_BIT];
            pin_ctrl_ff[PIN0_OUT_EN_BIT] <= reg_wdata_in[PIN0_OUT_EN_BIT];
            pin_ctrl_ff[PIN1_LEVEL_BIT] <= reg_wdata_in[PIN1_LEVEL_BIT];
            pin_ctrl_ff[PIN0_LEVEL_BIT] <= reg_wdata_in[PIN0_LEVEL_BIT];
        end
    end

    // Channel zero: reserved bits 11..10 stay zero.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ch0_cfg_ff <= CH0_RESET;
        end
        else if (write_hit(reg_wr_in, reg_addr_in, CH0_ADDR))
        begin
            ch0_cfg_ff <= reg_wdata_in & CH0_WRITE_MASK;
        end
    end

    assign pins.pin0_input_enable = pin_ctrl_ff[PIN0_IN_EN_BIT];
    assign pins.pin1_input_enable = pin_ctrl_ff[PIN1_IN_EN_BIT];
    assign pins.pin0_output_enable = pin_ctrl_ff[PIN0_OUT_EN_BIT];
    assign pins.pin1_output_enable = pin_ctrl_ff[PIN1_OUT_EN_BIT];
    assign pins.pin0_level = pin_ctrl_ff[PIN0_LEVEL_BIT];
    assign pins.pin1_level = pin_ctrl_ff[PIN1_LEVEL_BIT];

    gicr_pin_cell u_pin_cell (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ctl(pins.pin_side),
        .general_pin_zero_in(general_pin_zero_in),
        .general_pin_zero_out(general_pin_zero_out),
        .general_pin_zero_oe_n_out(general_pin_zero_oe_n_out),
        .general_pin_one_in(general_pin_one_in),
        .general_pin_one_out(general_pin_one_out),
        .general_pin_one_oe_n_out(general_pin_one_oe_n_out)
    );

    // An input pin reads its sampled level; otherwise the stored data bit.
    always_comb
    begin
        pin_readback = pin_ctrl_ff;
        if (pin_ctrl_ff[PIN0_IN_EN_BIT])
        begin
            pin_readback[PIN0_LEVEL_BIT] = pins.pin0_sampled;
        end
        if (pin_ctrl_ff[PIN1_IN_EN_BIT])
        begin
            pin_readback[PIN1_LEVEL_BIT] = pins.pin1_sampled;
        end
    end

    always_comb
    begin
        case (reg_addr_in)
            PIN_CTRL_ADDR: nxt_rdata = pin_readback;
            ID_ADDR: nxt_rdata = ID_CODE;
            CH0_ADDR: nxt_rdata = ch0_cfg_ff;
            default: nxt_rdata = READ_ZERO;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            rdata_ff <= READ_ZERO;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= reg_rd_in;
            if (reg_rd_in)
            begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign ch_enables = {other_ch_enable_in, ch0_cfg_ff[CH_EN_BIT]};

    // Each finished conversion moves on to the next enabled channel.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            active_ch_ff <= '0;
        end
        else if (conv_done_in || !ch_enables[active_ch_ff])
        begin
            active_ch_ff <= next_enabled(ch_enables, active_ch_ff);
        end
    end

    // Channel zero's setup comes from its own field, others from their registers.
    always_comb
    begin
        if (active_ch_ff == '0)
        begin
            active_setup_out = ch0_cfg_ff[SETUP_HI:SETUP_LO];
        end
        else
        begin
            active_setup_out = ch_setup_in[SETUP_W*active_ch_ff +: SETUP_W];
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign reg_rvalid_out = rvalid_ff;
    assign active_ch_out = active_ch_ff;
    assign channel_zero_enable_out = ch0_cfg_ff[CH_EN_BIT];
    assign channel_zero_setup_index_out = ch0_cfg_ff[SETUP_HI:SETUP_LO];
endmodule
`default_nettype wire
